/* File: rtl/ebp_pkg.sv */
// Purpose: Shared constants for the eight-bit port with edge interrupts
// Assumes: AHB-Lite word access, register index times four is the byte address
// Notes: Indices are the printed register numbers
package ebp_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned IDX_W = 16;
    localparam int unsigned WORD_W = 30;

    // Register indices; byte address is index * 4
    localparam logic [15:0] IDX_PIN_LEVEL = 16'h5200;
    localparam logic [15:0] IDX_DRIVE_VALUE = 16'h5201;
    localparam logic [15:0] IDX_DRIVE_ENABLE = 16'h5202;
    localparam logic [15:0] IDX_PULLUP_ENABLE = 16'h5203;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h5205;
    localparam logic [15:0] IDX_IRQ_POLARITY = 16'h5206;
    localparam logic [15:0] IDX_IRQ_PENDING = 16'h5207;

    // Reset values
    localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
    localparam logic [7:0] RST_DRIVE_VALUE = 8'h00;
    localparam logic [7:0] RST_DRIVE_ENABLE = 8'h00;
    localparam logic [7:0] RST_PULLUP_ENABLE = 8'hFF;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_POLARITY = 8'h00;
    localparam logic [7:0] RST_IRQ_PENDING = 8'h00;

    // Bus encodings
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
    localparam logic [23:0] RDATA_PAD = 24'h000000;
    localparam logic [13:0] WORD_PAD = 14'h0000;

    // Data phase state of the bus slave
    typedef enum logic [1:0] {
        EBP_IDLE = 2'b00,
        EBP_WRITE = 2'b01,
        EBP_READ_WAIT = 2'b10,
        EBP_READ_OUT = 2'b11
    } ebp_phase_t;
endpackage

/* File: rtl/ebp_edge_detect.sv */
// Purpose: Pin level sampling and per-pin selectable edge detection
// Assumes: Pin inputs synchronous to hclk
// Notes: No edge is reported until two samples have been taken after reset
module ebp_edge_detect (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] irq_polarity,
    output logic [7:0] pin_level,
    output logic [7:0] edge_event
);
    logic primed;
    logic sampled;
    logic [7:0] prev_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_level <= ebp_pkg::RST_PIN_LEVEL;
            prev_level <= ebp_pkg::RST_PIN_LEVEL;
            sampled <= 1'b0;
            primed <= 1'b0;
        end else begin
            pin_level <= pin_in;
            prev_level <= pin_level;
            sampled <= 1'b1;
            primed <= sampled;
        end
    end

    always_comb begin
        edge_event = primed ? ((irq_polarity & prev_level & ~pin_level)
            | (~irq_polarity & ~prev_level & pin_level)) : 8'h00;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_level_follows: assert property (hresetn |=> pin_level == $past(pin_in))
        else $error("pin level does not follow pin input");
    a_fall_select: assert property (primed
        |-> (edge_event & irq_polarity) == (irq_polarity & $past(pin_level) & ~pin_level))
        else $error("falling edge report disagrees with polarity one");
    a_no_wrong_edge: assert property (primed
        |-> (edge_event & ~irq_polarity) == (~irq_polarity & ~$past(pin_level) & pin_level))
        else $error("rising edge report disagrees with polarity zero");
endmodule // ebp_edge_detect

/* File: rtl/ebp_port.sv */
// Purpose: Eight-bit general-purpose port with edge interrupts behind AHB-Lite
// Assumes: Single slave, word transfers, one wait state on reads
// Notes: Pin resolution and pull-up devices live outside this block
// What this block does
// - Read-only register returns each pin's present logic level.
// - Readable writable output data value per pin, cleared at reset.
// - Pin driven from its data bit only while its enable is one.
// - Per-pin pull-up enable, readable writable, all ones after reset.
// - Per-pin interrupt enable, readable writable, cleared at reset.
// - Polarity one selects falling edge, zero rising edge; resets to zero.
// - Selected edge sets pending flag; writing one clears it; reset zero.
//
// Implementation choice: the AHB-Lite interface to the registers.
module ebp_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_en,
    output logic irq
);
    ebp_pkg::ebp_phase_t phase;
    ebp_pkg::ebp_phase_t next_phase;
    logic [29:0] dp_word;
    logic addr_take;
    logic [7:0] port_pin_level;
    logic [7:0] port_drive_value;
    logic [7:0] port_drive_enable;
    logic [7:0] port_pullup_enable;
    logic [7:0] port_irq_enable;
    logic [7:0] port_irq_polarity;
    logic [7:0] port_irq_pending;
    logic [7:0] edge_event;
    logic [7:0] read_value;
    logic wr_drive_value;
    logic wr_drive_enable;
    logic wr_pullup_enable;
    logic wr_irq_enable;
    logic wr_irq_polarity;
    logic wr_irq_pending;

    function automatic logic reg_hit(input logic [29:0] word, input logic [15:0] idx);
        reg_hit = (word == {ebp_pkg::WORD_PAD, idx});
    endfunction

    ebp_edge_detect u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(pin_in),
        .irq_polarity(port_irq_polarity),
        .pin_level(port_pin_level),
        .edge_event(edge_event)
    );

    // Address phase acceptance
    assign addr_take = hsel && htrans[ebp_pkg::HTRANS_ACTIVE_BIT] && hready;
    assign hreadyout = (phase != ebp_pkg::EBP_READ_WAIT);
    assign hresp = ebp_pkg::HRESP_OKAY;

    always_comb begin
        if (addr_take) begin
            next_phase = hwrite ? ebp_pkg::EBP_WRITE : ebp_pkg::EBP_READ_WAIT;
        end else if (phase == ebp_pkg::EBP_READ_WAIT) begin
            next_phase = ebp_pkg::EBP_READ_OUT;
        end else begin
            next_phase = ebp_pkg::EBP_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= ebp_pkg::EBP_IDLE;
            dp_word <= '0;
        end else begin
            phase <= next_phase;
            if (addr_take) begin
                dp_word <= haddr[31:2];
            end
        end
    end

    // Write strobes in the data phase
    always_comb begin
        wr_drive_value = 1'b0;
        wr_drive_enable = 1'b0;
        wr_pullup_enable = 1'b0;
        wr_irq_enable = 1'b0;
        wr_irq_polarity = 1'b0;
        wr_irq_pending = 1'b0;
        case (phase)
            ebp_pkg::EBP_WRITE: begin
                wr_drive_value = reg_hit(dp_word, ebp_pkg::IDX_DRIVE_VALUE);
                wr_drive_enable = reg_hit(dp_word, ebp_pkg::IDX_DRIVE_ENABLE);
                wr_pullup_enable = reg_hit(dp_word, ebp_pkg::IDX_PULLUP_ENABLE);
                wr_irq_enable = reg_hit(dp_word, ebp_pkg::IDX_IRQ_ENABLE);
                wr_irq_polarity = reg_hit(dp_word, ebp_pkg::IDX_IRQ_POLARITY);
                wr_irq_pending = reg_hit(dp_word, ebp_pkg::IDX_IRQ_PENDING);
            end
            default: begin
                wr_drive_value = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_drive_value <= ebp_pkg::RST_DRIVE_VALUE;
        end else if (wr_drive_value) begin
            port_drive_value <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_drive_enable <= ebp_pkg::RST_DRIVE_ENABLE;
        end else if (wr_drive_enable) begin
            port_drive_enable <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_pullup_enable <= ebp_pkg::RST_PULLUP_ENABLE;
        end else if (wr_pullup_enable) begin
            port_pullup_enable <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_irq_enable <= ebp_pkg::RST_IRQ_ENABLE;
        end else if (wr_irq_enable) begin
            port_irq_enable <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_irq_polarity <= ebp_pkg::RST_IRQ_POLARITY;
        end else if (wr_irq_polarity) begin
            port_irq_polarity <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_irq_pending <= ebp_pkg::RST_IRQ_PENDING;
        end else if (wr_irq_pending) begin
            port_irq_pending <= (port_irq_pending & ~hwdata[7:0]) | edge_event;
        end else begin
            port_irq_pending <= port_irq_pending | edge_event;
        end
    end

    assign irq = |(port_irq_pending & port_irq_enable);

    assign pin_out = port_drive_value;
    assign pin_oe = port_drive_enable;
    assign pullup_en = port_pullup_enable;

    always_comb begin
        read_value = 8'h00;
        if (reg_hit(dp_word, ebp_pkg::IDX_PIN_LEVEL)) begin
            read_value = port_pin_level;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_DRIVE_VALUE)) begin
            read_value = port_drive_value;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_DRIVE_ENABLE)) begin
            read_value = port_drive_enable;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_PULLUP_ENABLE)) begin
            read_value = port_pullup_enable;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_IRQ_ENABLE)) begin
            read_value = port_irq_enable;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_IRQ_POLARITY)) begin
            read_value = port_irq_polarity;
        end else if (reg_hit(dp_word, ebp_pkg::IDX_IRQ_PENDING)) begin
            read_value = port_irq_pending;
        end
    end

    // Read data register, loaded in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= ebp_pkg::RDATA_ZERO;
        end else if (phase == ebp_pkg::EBP_READ_WAIT) begin
            hrdata <= {ebp_pkg::RDATA_PAD, read_value};
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_read_wait: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait state");
    a_drive_store: assert property (wr_drive_value |=> port_drive_value == $past(hwdata[7:0]))
        else $error("output data write not stored");
    a_oe_follows: assert property (wr_drive_enable |=> pin_oe == $past(hwdata[7:0]))
        else $error("driver enable not taken from write");
    a_pullup_store: assert property (wr_pullup_enable |=> pullup_en == $past(hwdata[7:0]))
        else $error("pull-up enable write not stored");
    a_enable_store: assert property (wr_irq_enable |=> port_irq_enable == $past(hwdata[7:0]))
        else $error("interrupt enable write not stored");
    a_pending_set: assert property (edge_event != 8'h00
        |=> (port_irq_pending & $past(edge_event)) == $past(edge_event))
        else $error("edge did not set pending flag");
    a_pending_clear: assert property (wr_irq_pending && edge_event == 8'h00
        |=> (port_irq_pending & $past(hwdata[7:0])) == 8'h00)
        else $error("writing one did not clear pending flag");
    a_zero_keeps: assert property (wr_irq_pending
        |=> (port_irq_pending & ~$past(hwdata[7:0]) & ~$past(edge_event))
            == $past(port_irq_pending & ~hwdata[7:0] & ~edge_event))
        else $error("writing zero changed a pending flag");
    a_irq_level: assert property (((port_irq_pending & port_irq_enable) != 8'h00) == irq)
        else $error("interrupt output disagrees with pending and enable");
    a_unmapped_zero: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && !reg_hit(dp_word, ebp_pkg::IDX_PIN_LEVEL) && read_value == 8'h00
        |=> hrdata == ebp_pkg::RDATA_ZERO)
        else $error("read data not loaded in wait cycle");

    // Bus protocol
    a_write_no_wait: assert property (addr_take && hwrite |=> hreadyout)
        else $error("write data phase inserted a wait state");
    a_resp_okay: assert property (hresp == ebp_pkg::HRESP_OKAY)
        else $error("response other than okay");
    a_rdata_pad: assert property (phase == ebp_pkg::EBP_READ_OUT
        |-> hrdata[31:8] == ebp_pkg::RDATA_PAD)
        else $error("upper read data bits not zero");
    a_rdata_hold: assert property (phase != ebp_pkg::EBP_READ_WAIT |=> $stable(hrdata))
        else $error("read data changed outside a read");
    a_strobe_phase: assert property (phase != ebp_pkg::EBP_WRITE
        |-> !(wr_drive_value || wr_drive_enable || wr_pullup_enable
            || wr_irq_enable || wr_irq_polarity || wr_irq_pending))
        else $error("write strobe outside a write data phase");
    a_strobe_single: assert property ($onehot0({wr_drive_value, wr_drive_enable,
        wr_pullup_enable, wr_irq_enable, wr_irq_polarity, wr_irq_pending}))
        else $error("more than one register written at once");

    // Register store and hold, interrupt output
    a_polarity_store: assert property (wr_irq_polarity
        |=> port_irq_polarity == $past(hwdata[7:0]))
        else $error("polarity write not stored");
    a_drive_hold: assert property (!wr_drive_value |=> $stable(port_drive_value))
        else $error("output data changed without a write");
    a_oe_hold: assert property (!wr_drive_enable |=> $stable(port_drive_enable))
        else $error("driver enable changed without a write");
    a_pullup_hold: assert property (!wr_pullup_enable |=> $stable(port_pullup_enable))
        else $error("pull-up enable changed without a write");
    a_enable_hold: assert property (!wr_irq_enable |=> $stable(port_irq_enable))
        else $error("interrupt enable changed without a write");
    a_polarity_hold: assert property (!wr_irq_polarity |=> $stable(port_irq_polarity))
        else $error("polarity changed without a write");
    a_irq_gate: assert property (port_irq_enable == 8'h00 |-> !irq)
        else $error("interrupt raised with all enables off");
    a_irq_on_edge: assert property ((edge_event & port_irq_enable) != 8'h00 && !wr_irq_enable
        |=> irq)
        else $error("enabled edge did not raise interrupt");

    // Readback
    a_read_level: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_PIN_LEVEL)
        |=> hrdata[7:0] == $past(port_pin_level))
        else $error("pin level read back wrong");
    a_read_drive: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_DRIVE_VALUE)
        |=> hrdata[7:0] == $past(port_drive_value))
        else $error("output data read back wrong");
    a_read_oe: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_DRIVE_ENABLE)
        |=> hrdata[7:0] == $past(port_drive_enable))
        else $error("driver enable read back wrong");
    a_read_pullup: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_PULLUP_ENABLE)
        |=> hrdata[7:0] == $past(port_pullup_enable))
        else $error("pull-up enable read back wrong");
    a_read_enable: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_IRQ_ENABLE)
        |=> hrdata[7:0] == $past(port_irq_enable))
        else $error("interrupt enable read back wrong");
    a_read_polarity: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_IRQ_POLARITY)
        |=> hrdata[7:0] == $past(port_irq_polarity))
        else $error("polarity read back wrong");
    a_read_pending: assert property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_IRQ_PENDING)
        |=> hrdata[7:0] == $past(port_irq_pending))
        else $error("pending flags read back wrong");

    // Pending flags
    a_pending_rise: assert property ((port_irq_pending & ~$past(port_irq_pending)
        & ~$past(edge_event)) == 8'h00)
        else $error("pending flag set without an edge");
    a_pending_keep: assert property (!wr_irq_pending
        |=> ($past(port_irq_pending) & ~port_irq_pending) == 8'h00)
        else $error("pending flag cleared without a write");

    c_edge_irq: cover property (edge_event != 8'h00 ##1 irq);
    c_w1c: cover property (wr_irq_pending && port_irq_pending != 8'h00);
    c_read_back: cover property (addr_take && !hwrite ##2 hreadyout);
    c_set_on_clear: cover property (wr_irq_pending && (edge_event & hwdata[7:0]) != 8'h00);
    c_level_read: cover property (phase == ebp_pkg::EBP_READ_WAIT
        && reg_hit(dp_word, ebp_pkg::IDX_PIN_LEVEL));
endmodule // ebp_port

/* File: bench/ebp_pin_model.sv */
// Purpose: Pin-side circuit of the port: drivers, external sources, pull-ups
// Assumes: Device drive wins over an external source on the same pin
// Notes: An undriven pin without pull-up toggles every cycle
module ebp_pin_model (
    input wire logic hclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_val = 8'h00;
    always_ff @(posedge hclk) begin
        float_val <= ~float_val;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_wire[i] = pin_out[i];
            else if (ext_en[i]) pin_wire[i] = ext_val[i];
            else if (pullup_en[i]) pin_wire[i] = 1'b1;
            else pin_wire[i] = float_val[i];
        end
    end
endmodule // ebp_pin_model

/* File: bench/ebp_port_test.sv */
// Purpose: Self-checking bench of the eight-bit port against a register model
// Assumes: Single AHB-Lite slave, hready tied to hreadyout
// Notes: Pin levels come from the pin model
module ebp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, irq;
    logic [1:0] hresp;
    logic [7:0] pin_in, pin_out, pin_oe, pullup_en, v0, v1, e;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    int err_count = 0;
    int cmp_count = 0;
    int mdl [8];

    ebp_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .irq(irq));
    ebp_pin_model pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_wire(pin_in));

    initial begin
        forever #2 hclk = ~hclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        chk("hreadyout", hreadyout, 32'h1);
    endtask

    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {14'h0000, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_ready();
        rd = hrdata;
        chk("hresp", {30'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        if (idx == ebp_pkg::IDX_IRQ_PENDING) mdl[7] &= ~d;
        else if (idx[2:0] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6}) mdl[idx[2:0]] = d;
    endtask

    task automatic rc(input logic [15:0] idx);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), rd, mdl[idx[2:0]]);
    endtask

    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        stop_test();
    end

    initial begin
        rd = $urandom(32'h006B);
        mdl = '{0, 0, 0, 255, 0, 0, 0, 0};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        chk("ports", {irq, pullup_en, pin_oe, pin_out}, {1'b0, 24'hFF0000});
        for (int i = 1; i < 8; i++) rc(16'h5200 + i);
        $display("Test reset values done");
        ext_en <= 8'hFF;
        for (int k = 0; k < 4; k++) begin
            for (int i = 1; i < 7; i++) wr(16'h5200 + i, 8'($urandom));
            wr(16'h5200, 8'($urandom));
            wr(16'h5204, 8'($urandom));
            for (int i = 1; i < 7; i++) rc(16'h5200 + i);
            chk("ports", {pullup_en, pin_oe, pin_out}, {8'(mdl[3]), 8'(mdl[2]), 8'(mdl[1])});
        end
        $display("Test register access done");
        for (int k = 0; k < 6; k++) begin
            e = 8'($urandom);
            ext_en <= e;
            ext_val <= 8'($urandom);
            wr(16'h5201, 8'($urandom));
            wr(16'h5202, 8'($urandom));
            wr(16'h5203, ~e | 8'($urandom));
            bus(1'b0, 16'h5200, 8'h00);
            chk("level", rd, 255 & (mdl[1] & mdl[2] | ~mdl[2] & (ext_val & e | ~e)));
        end
        $display("Test pin levels done");
        ext_en <= 8'hFF;
        wr(16'h5202, 8'h00);
        for (int k = 0; k < 8; k++) begin
            v0 = 8'($urandom);
            v1 = 8'($urandom);
            ext_val <= v0;
            wr(16'h5206, 8'($urandom));
            wr(16'h5205, 8'($urandom));
            wr(16'h5207, 8'hFF);
            ext_val <= v1;
            repeat (4) @(posedge hclk);
            mdl[7] = 255 & (v0 & ~v1 & mdl[6] | ~v0 & v1 & ~mdl[6]);
            chk("irq", irq, |(mdl[7] & mdl[5]));
            rc(16'h5207);
            wr(16'h5207, 8'h00);
            rc(16'h5207);
            wr(16'h5207, 8'($urandom));
            rc(16'h5207);
            chk("irq", irq, |(mdl[7] & mdl[5]));
        end
        $display("Test edge interrupts done");
        ext_val <= 8'h5A;
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("ports", {irq, pullup_en, pin_oe, pin_out}, {1'b0, 24'hFF0000});
        hresetn <= 1'b1;
        mdl = '{0, 0, 0, 255, 0, 0, 0, 0};
        repeat (4) @(posedge hclk);
        rc(16'h5207);
        rc(16'h5203);
        bus(1'b0, 16'h5200, 8'h00);
        chk("level", rd, 32'h0000005A);
        $display("Test second reset done");
        stop_test();
    end
endmodule // ebp_port_test
